// *** uart_pins_pkg.sv ***
// Contract
// - Serial output idles high, reset, disabled
// - Loopback keeps pin high, feeds receiver internally
// - Loopback receiver ignores the external pin
// - Receive ready low with characters waiting (mode 0) or at trigger level (mode 1)
// - Receive ready high if empty or untriggered
// - Transmit ready low while space is free (mode 1) or when empty (mode 0)
// - Each channel has own pins and status
// - Oscillator input takes crystal or clock
package uart_pins_pkg;
  localparam int          FIFO_DEPTH  = 128;
  localparam int          CNT_W       = 8;
  localparam logic [7:0]  CNT_EMPTY   = 8'h00;
  localparam logic [7:0]  CNT_ONE     = 8'h01;
  localparam logic [7:0]  CNT_FULL    = 8'h80;
  localparam logic        LINE_IDLE   = 1'b1;
  localparam logic        REQ_OFF     = 1'b1;
  localparam logic        REQ_ON      = 1'b0;
  localparam logic        DMA_MODE0   = 1'b0;
  localparam logic        DMA_MODE1   = 1'b1;
  localparam logic [1:0]  SYNC_RESET  = 2'h3;
  localparam logic        OSC_RESET   = 1'b0;
endpackage

// *** uart_serial_pins_dma_ready.sv ***
`timescale 1ns/1ps
module uart_pins_chan (
  input  wire logic       CLK,          // System clock
  input  wire logic       RST,          // Async reset, active high
  input  wire logic       serial_in_i,  // Receive pin, asynchronous
  input  wire logic       tx_bit_i,     // Transmit bit stream
  input  wire logic       tx_active_i,  // Transmitter is sending
  input  wire logic       tx_en_i,      // Transmitter enabled
  input  wire logic       loop_i,       // Local loopback
  input  wire logic       dma_mode_i,   // 0 single, 1 block
  input  wire logic [7:0] rx_cnt_i,     // Receive characters held
  input  wire logic [7:0] rx_trig_i,    // Receive trigger level
  input  wire logic [7:0] tx_cnt_i,     // Transmit characters held
  output logic            serial_out_q, // Transmit pin
  output logic            rx_bit_q,     // Bit into receiver
  output logic            rx_req_n_q,   // Receive ready, low active
  output logic            tx_req_n_q    // Transmit ready, low active
);
  logic [1:0] sync_q;
  logic [1:0] sync_d;
  logic       serial_out_d;
  logic       rx_bit_d;
  logic       rx_req_n_d;
  logic       tx_req_n_d;
  logic       tx_line;
  logic [7:0] rx_level;

  always_comb
  begin
    sync_d       = {sync_q[0], serial_in_i};
    tx_line      = (tx_en_i && tx_active_i) ? tx_bit_i : uart_pins_pkg::LINE_IDLE;
    // Loopback still shifts the pin synchroniser so leaving loopback sees a settled level
    serial_out_d = loop_i ? uart_pins_pkg::LINE_IDLE : tx_line;
    rx_bit_d     = loop_i ? tx_line : sync_q[1];
    // A zero trigger would fire on an empty buffer, so the level floors at one
    rx_level     = (rx_trig_i == uart_pins_pkg::CNT_EMPTY) ? uart_pins_pkg::CNT_ONE : rx_trig_i;
    rx_req_n_d   = uart_pins_pkg::REQ_OFF;
    tx_req_n_d   = uart_pins_pkg::REQ_OFF;
    case (dma_mode_i)
      uart_pins_pkg::DMA_MODE0:
      begin
        if (rx_cnt_i != uart_pins_pkg::CNT_EMPTY)
          rx_req_n_d = uart_pins_pkg::REQ_ON;
        if (tx_cnt_i == uart_pins_pkg::CNT_EMPTY)
          tx_req_n_d = uart_pins_pkg::REQ_ON;
      end
      uart_pins_pkg::DMA_MODE1:
      begin
        if (rx_cnt_i >= rx_level)
          rx_req_n_d = uart_pins_pkg::REQ_ON;
        if (tx_cnt_i < uart_pins_pkg::CNT_FULL)
          tx_req_n_d = uart_pins_pkg::REQ_ON;
      end
      default:
      begin
        rx_req_n_d = uart_pins_pkg::REQ_OFF;
        tx_req_n_d = uart_pins_pkg::REQ_OFF;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      sync_q       <= uart_pins_pkg::SYNC_RESET;
      serial_out_q <= uart_pins_pkg::LINE_IDLE;
      rx_bit_q     <= uart_pins_pkg::LINE_IDLE;
      rx_req_n_q   <= uart_pins_pkg::REQ_OFF;
      tx_req_n_q   <= uart_pins_pkg::REQ_OFF;
    end
    else
    begin
      sync_q       <= sync_d;
      serial_out_q <= serial_out_d;
      rx_bit_q     <= rx_bit_d;
      rx_req_n_q   <= rx_req_n_d;
      tx_req_n_q   <= tx_req_n_d;
    end
  end

  property p_idle_high;
    @(posedge CLK) disable iff (RST) (!tx_en_i || !tx_active_i) |=> serial_out_q;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("serial out not idle high");

  property p_send;
    @(posedge CLK) disable iff (RST)
      (tx_en_i && tx_active_i && !loop_i) |=> serial_out_q == $past(tx_bit_i);
  endproperty
  a_send: assert property (p_send) else $error("serial out not following tx bit");

  property p_loop_pin;
    @(posedge CLK) disable iff (RST) loop_i [*2] |=> serial_out_q [*1];
  endproperty
  a_loop_pin: assert property (p_loop_pin) else $error("pin driven in loopback");

  property p_loop_rx;
    @(posedge CLK) disable iff (RST)
      loop_i |=> rx_bit_q == $past((tx_en_i && tx_active_i) ? tx_bit_i : 1'b1);
  endproperty
  a_loop_rx: assert property (p_loop_rx) else $error("loopback rx not from tx");

  property p_pin_rx;
    @(posedge CLK) disable iff (RST)
      !loop_i ##1 !loop_i ##1 !loop_i |=> rx_bit_q == $past(serial_in_i, 3);
  endproperty
  a_pin_rx: assert property (p_pin_rx) else $error("rx bit not pin after sync");

  property p_rx0;
    @(posedge CLK) disable iff (RST)
      (dma_mode_i == uart_pins_pkg::DMA_MODE0) |=> rx_req_n_q == ($past(rx_cnt_i) == 8'h00);
  endproperty
  a_rx0: assert property (p_rx0) else $error("mode 0 rx ready wrong");

  property p_rx1;
    @(posedge CLK) disable iff (RST)
      (dma_mode_i == uart_pins_pkg::DMA_MODE1 && (rx_cnt_i < rx_trig_i || rx_cnt_i == 8'h00))
      |=> rx_req_n_q;
  endproperty
  a_rx1: assert property (p_rx1) else $error("rx ready low below trigger");

  property p_tx1_free;
    @(posedge CLK) disable iff (RST)
      (dma_mode_i == uart_pins_pkg::DMA_MODE1 && tx_cnt_i < 8'h80) |=> !tx_req_n_q;
  endproperty
  a_tx1_free: assert property (p_tx1_free) else $error("tx ready high with space");

  property p_tx1_full;
    @(posedge CLK) disable iff (RST)
      (dma_mode_i == uart_pins_pkg::DMA_MODE1 && tx_cnt_i >= 8'h80) |=> tx_req_n_q;
  endproperty
  a_tx1_full: assert property (p_tx1_full) else $error("tx ready low when full");

  property p_tx0;
    @(posedge CLK) disable iff (RST)
      (dma_mode_i == uart_pins_pkg::DMA_MODE0) |=> tx_req_n_q == ($past(tx_cnt_i) != 8'h00);
  endproperty
  a_tx0: assert property (p_tx0) else $error("mode 0 tx ready wrong");

  c_loop: cover property (@(posedge CLK) disable iff (RST) loop_i && tx_active_i && !tx_bit_i);
  c_rx_trig: cover property (@(posedge CLK) disable iff (RST) $fell(rx_req_n_q) && dma_mode_i);
  c_tx_full: cover property (@(posedge CLK) disable iff (RST) $rose(tx_req_n_q) && dma_mode_i);
  c_mode0: cover property (@(posedge CLK) disable iff (RST) !dma_mode_i && $fell(tx_req_n_q));
endmodule // uart_pins_chan

module uart_serial_pins_dma_ready (
  input  wire logic       CLK,                  // 10 MHz system clock
  input  wire logic       RST,                  // Async reset, active high
  input  wire logic       OSC_IN,               // Crystal or external clock pin
  input  wire logic       OSC_EXT,              // 1: external clock on OSC_IN
  output logic            OSC_OUT,              // Oscillator drive (inverted input), held low with external clock
  output logic            OSC_TICK,             // Pulse on each reference rising edge
  input  wire logic [1:0] SERIAL_IN,            // Receive pins, [0]=A [1]=B
  input  wire logic [1:0] TX_BIT,               // Transmit bit streams
  input  wire logic [1:0] TX_ACTIVE,            // Transmitters sending
  input  wire logic [1:0] TX_EN,                // Transmitters enabled
  input  wire logic [1:0] LOOPBACK,             // Local loopback per channel
  input  wire logic [1:0] DMA_MODE,             // DMA mode per channel
  input  wire logic [7:0] RX_CNT_A,             // Receive fill, channel A
  input  wire logic [7:0] RX_CNT_B,             // Receive fill, channel B
  input  wire logic [7:0] RX_TRIG_A,            // Receive trigger, channel A
  input  wire logic [7:0] RX_TRIG_B,            // Receive trigger, channel B
  input  wire logic [7:0] TX_CNT_A,             // Transmit fill, channel A
  input  wire logic [7:0] TX_CNT_B,             // Transmit fill, channel B
  output logic            SERIAL_OUT_CHAN_A,    // Transmit pin A
  output logic            SERIAL_OUT_CHAN_B,    // Transmit pin B
  output logic [1:0]      RX_BIT,               // Bits into receivers
  output logic            RX_DMA_REQ_N_CHAN_A,  // Receive ready A
  output logic            RX_DMA_REQ_N_CHAN_B,  // Receive ready B
  output logic            TX_DMA_REQ_N_CHAN_A,  // Transmit ready A
  output logic            TX_DMA_REQ_N_CHAN_B   // Transmit ready B
);
  logic [1:0] osc_sync_q;
  logic [1:0] osc_sync_d;
  logic       osc_prev_q;
  logic       osc_prev_d;
  logic       osc_out_d;
  logic       osc_tick_d;

  // The pin is only sampled; edges faster than CLK/2 are lost, so the reference stays slow
  always_comb
  begin
    osc_sync_d = {osc_sync_q[0], OSC_IN};
    osc_prev_d = osc_sync_q[1];
    osc_out_d  = OSC_EXT ? uart_pins_pkg::OSC_RESET : !osc_sync_q[1];
    osc_tick_d = osc_sync_q[1] && !osc_prev_q;
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      osc_sync_q <= {uart_pins_pkg::OSC_RESET, uart_pins_pkg::OSC_RESET};
      osc_prev_q <= uart_pins_pkg::OSC_RESET;
      OSC_OUT    <= uart_pins_pkg::OSC_RESET;
      OSC_TICK   <= uart_pins_pkg::OSC_RESET;
    end
    else
    begin
      osc_sync_q <= osc_sync_d;
      osc_prev_q <= osc_prev_d;
      OSC_OUT    <= osc_out_d;
      OSC_TICK   <= osc_tick_d;
    end
  end

  // Channels share no state; each sees only its own counts
  uart_pins_chan chan_a (
    .CLK          (CLK),
    .RST          (RST),
    .serial_in_i  (SERIAL_IN[0]),
    .tx_bit_i     (TX_BIT[0]),
    .tx_active_i  (TX_ACTIVE[0]),
    .tx_en_i      (TX_EN[0]),
    .loop_i       (LOOPBACK[0]),
    .dma_mode_i   (DMA_MODE[0]),
    .rx_cnt_i     (RX_CNT_A),
    .rx_trig_i    (RX_TRIG_A),
    .tx_cnt_i     (TX_CNT_A),
    .serial_out_q (SERIAL_OUT_CHAN_A),
    .rx_bit_q     (RX_BIT[0]),
    .rx_req_n_q   (RX_DMA_REQ_N_CHAN_A),
    .tx_req_n_q   (TX_DMA_REQ_N_CHAN_A)
  );

  uart_pins_chan chan_b (
    .CLK          (CLK),
    .RST          (RST),
    .serial_in_i  (SERIAL_IN[1]),
    .tx_bit_i     (TX_BIT[1]),
    .tx_active_i  (TX_ACTIVE[1]),
    .tx_en_i      (TX_EN[1]),
    .loop_i       (LOOPBACK[1]),
    .dma_mode_i   (DMA_MODE[1]),
    .rx_cnt_i     (RX_CNT_B),
    .rx_trig_i    (RX_TRIG_B),
    .tx_cnt_i     (TX_CNT_B),
    .serial_out_q (SERIAL_OUT_CHAN_B),
    .rx_bit_q     (RX_BIT[1]),
    .rx_req_n_q   (RX_DMA_REQ_N_CHAN_B),
    .tx_req_n_q   (TX_DMA_REQ_N_CHAN_B)
  );
endmodule // uart_serial_pins_dma_ready

// *** remote_serial_dev.sv ***
`timescale 1ns/1ps
module remote_serial_dev #(
  parameter int BIT_CYC = 3     // Short bit time keeps frames frequent
) (
  input  wire logic       CLK,  // Bench clock
  input  wire logic       RST,  // Bench reset, active high
  input  wire logic       SEND, // Start one character when idle
  input  wire logic [7:0] DATA, // Character to send
  output logic            LINE  // Serial line into the receiver
);
  logic [9:0] frame = 10'h3ff;
  int         left  = 0;
  logic       go_q  = 1'b0;
  logic       rst_q = 1'b1;
  logic [7:0] dat_q = 8'h00;
  initial LINE = 1'b1;
  // Requests are taken on the rising edge, clear of the bench's falling-edge writes
  always @(posedge CLK)
  begin
    go_q  <= SEND;
    rst_q <= RST;
    dat_q <= DATA;
  end
  // Falling edge only, so the receiver never samples a moving line
  always @(negedge CLK)
  begin
    if (rst_q)
      left = 0;
    else if (left == 0 && go_q)
    begin
      frame = {1'b1, dat_q, 1'b0};
      left  = 10 * BIT_CYC;
    end
    if (left == 0)
      LINE = 1'b1;
    else
    begin
      LINE = frame[0];
      left = left - 1;
      if (left % BIT_CYC == 0)
        frame = frame >> 1;
    end
  end
endmodule // remote_serial_dev

// *** uart_serial_pins_dma_ready_tb.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    checks_done++; \
    if ((got) !== (ex)) \
    begin \
      failures++; \
      $display("Error %s expected %h seen %h", nm, ex, got); \
    end \
  end
module uart_serial_pins_dma_ready_tb;
  localparam logic [7:0] CORNER [4] = '{8'h00, 8'h01, 8'h7f, 8'h80};
  logic        CLK = 1'b0;
  logic        RST = 1'b1;
  logic        osc_in = 1'b0, osc_ext = 1'b0;
  logic [1:0]  tx_bit = 2'h0, tx_act = 2'h0, tx_en = 2'h0, loop = 2'h0, mode = 2'h0;
  logic [1:0]  send = 2'h0;
  logic [7:0]  pdata = 8'h00;
  logic [7:0]  rx_cnt [2] = '{8'h00, 8'h00};
  logic [7:0]  rx_trig [2] = '{8'h00, 8'h00};
  logic [7:0]  tx_cnt [2] = '{8'h00, 8'h00};
  logic [2:0]  rxh0, rxh1;
  logic [3:0]  osch;
  logic        ln;
  logic [31:0] seed = 32'h00000bd4;
  int          failures = 0;
  int          checks_done = 0;
  wire logic [1:0] line, ser_out, rx_bit, rx_req_n, tx_req_n;
  wire logic       osc_out, osc_tick;
  initial forever #50 CLK = ~CLK;
  remote_serial_dev rem_a_u (.CLK(CLK), .RST(RST), .SEND(send[0]), .DATA(pdata), .LINE(line[0]));
  remote_serial_dev rem_b_u (.CLK(CLK), .RST(RST), .SEND(send[1]), .DATA(~pdata), .LINE(line[1]));
  uart_serial_pins_dma_ready dut_u (
    .CLK(CLK), .RST(RST), .OSC_IN(osc_in), .OSC_EXT(osc_ext), .OSC_OUT(osc_out),
    .OSC_TICK(osc_tick), .SERIAL_IN(line), .TX_BIT(tx_bit), .TX_ACTIVE(tx_act),
    .TX_EN(tx_en), .LOOPBACK(loop), .DMA_MODE(mode), .RX_CNT_A(rx_cnt[0]),
    .RX_CNT_B(rx_cnt[1]), .RX_TRIG_A(rx_trig[0]), .RX_TRIG_B(rx_trig[1]),
    .TX_CNT_A(tx_cnt[0]), .TX_CNT_B(tx_cnt[1]), .SERIAL_OUT_CHAN_A(ser_out[0]),
    .SERIAL_OUT_CHAN_B(ser_out[1]), .RX_BIT(rx_bit), .RX_DMA_REQ_N_CHAN_A(rx_req_n[0]),
    .RX_DMA_REQ_N_CHAN_B(rx_req_n[1]), .TX_DMA_REQ_N_CHAN_A(tx_req_n[0]),
    .TX_DMA_REQ_N_CHAN_B(tx_req_n[1])
  );
  // Pin history mirrors the two-stage synchronisers and their reset levels
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      rxh0 <= 3'h7;
      rxh1 <= 3'h7;
      osch <= 4'h0;
    end
    else
    begin
      rxh0 <= {rxh0[1:0], line[0]};
      rxh1 <= {rxh1[1:0], line[1]};
      osch <= {osch[2:0], osc_in};
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] pick(logic [31:0] v);
    return v[8] ? CORNER[v[1:0]] : 8'(v[31:24] % 129);
  endfunction
  function automatic logic exp_rx(logic m, logic [7:0] c, logic [7:0] t);
    return m ? !(c >= ((t == 8'h00) ? 8'h01 : t)) : (c == 8'h00);
  endfunction
  function automatic logic exp_tx(logic m, logic [7:0] c);
    return m ? (c >= uart_pins_pkg::CNT_FULL) : (c != 8'h00);
  endfunction
  task automatic summarize();
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic hold_reset(int cycles);
    RST = 1'b1;
    repeat (cycles) @(negedge CLK);
    `CHK("reset_outs", 10'h3fc, {ser_out, rx_bit, rx_req_n, tx_req_n, osc_out, osc_tick})
    RST = 1'b0;
  endtask
  task automatic drive();
    logic [31:0] r;
    r = rnd();
    osc_in = r[0];
    osc_ext = r[1] & r[2];
    tx_bit = r[4:3];
    tx_act = r[6:5] | {2{r[7]}};
    tx_en = r[9:8] | {2{r[10]}};
    loop = r[12:11] & {2{r[13]}};
    mode = r[15:14];
    send = r[19:18];
    pdata = r[31:24];
    for (int ch = 0; ch < 2; ch++)
    begin
      rx_cnt[ch] = pick(rnd());
      rx_trig[ch] = r[16 + ch] ? rx_cnt[ch] : pick(rnd());
      tx_cnt[ch] = pick(rnd());
    end
  endtask
  task automatic check_outs();
    for (int ch = 0; ch < 2; ch++)
    begin
      ln = (tx_en[ch] & tx_act[ch]) ? tx_bit[ch] : 1'b1;
      `CHK("serial_out", loop[ch] ? 1'b1 : ln, ser_out[ch])
      `CHK("rx_bit", loop[ch] ? ln : (ch == 1 ? rxh1[2] : rxh0[2]), rx_bit[ch])
      `CHK("rx_req_n", exp_rx(mode[ch], rx_cnt[ch], rx_trig[ch]), rx_req_n[ch])
      `CHK("tx_req_n", exp_tx(mode[ch], tx_cnt[ch]), tx_req_n[ch])
    end
    `CHK("osc_out", osc_ext ? 1'b0 : ~osch[2], osc_out)
    `CHK("osc_tick", osch[2] & ~osch[3], osc_tick)
  endtask
  initial
  begin
    hold_reset(12);
    for (int i = 0; i < 4000; i++)
    begin
      if (i == 2000)
        hold_reset(1);
      drive();
      @(negedge CLK);
      check_outs();
    end
    summarize();
  end
endmodule // uart_serial_pins_dma_ready_tb
